// ===== tb/rds_far_side.sv
`timescale 1ns/1ps
module rds_far_side #(
   parameter int TICK = 3
) (
   input wire logic sys_clk_in,
   input wire logic osc_on_in,
   input wire logic pll_ok_in,
   input wire logic clk_ok_in,
   output rds_pkg::rds_src_type src_out,
   output rds_pkg::rds_osc_type osc_out
);
   import rds_pkg::*;
   int div;
   initial begin
      src_out = '0;
      osc_out = '0;
      div = 0;
   end
   // the oscillator stands still until it is switched on, as a slow crystal would
   always @(posedge sys_clk_in) begin
      if (osc_on_in) begin
         div <= (div == TICK - 1) ? 0 : div + 1;
         if (div == TICK - 1) begin
            osc_out.osc_tick <= ~osc_out.osc_tick;
         end
      end
      osc_out.pll_locked <= pll_ok_in;
      osc_out.clk_valid <= clk_ok_in;
   end
   // a reset source is a level; only its rising edge counts as the event
   task automatic fire(input int idx);
      src_out[idx] <= 1'b1;
      repeat (6) @(posedge sys_clk_in);
      src_out[idx] <= 1'b0;
   endtask
endmodule

// ===== tb/reset_delay_sequencer_test.sv
`timescale 1ns/1ps
`include "rds_defs.svh"
module reset_delay_sequencer_test;
   import rds_pkg::*;
   localparam int PW = 50;
   localparam int MW = 20;
   localparam int TK = 3;
   logic sys_clk_in, rst_n_in, hwrite, hsel, hready, hresp;
   logic rel, clk_rel, run, internal_fast_rc_osc, trap, mon, irq, osc_on, pll_ok, clk_ok;
   logic [31:0] haddr, hwdata, hrdata, rd, m, s;
   logic [1:0] htrans;
   logic [4:0] outs;
   rds_clk_src_type src;
   rds_src_type srcs;
   rds_osc_type osc;
   int failures, samples_checked, cyc, t0, i, k;
   assign outs = {internal_fast_rc_osc, trap, mon, clk_rel, rel};
   rds_reset_sequencer #(.POWER_UP_TIMER_CYCLES(PW), .MON_CYCLES(MW)) u_dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
      .src_in(srcs), .osc_in(osc), .clk_src_in(src), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hsel_in(hsel), .hready_in(hready), .hwdata_in(hwdata), .hrdata_out(hrdata),
      .hreadyout_out(hready), .hresp_out(hresp), .internal_system_reset_out(rel), .clock_release_out(clk_rel),
      .run_enable_out(run), .use_fast_rc_out(internal_fast_rc_osc), .fail_trap_out(trap), .monitor_active_out(mon), .irq_out(irq));
   rds_far_side #(.TICK(TK)) u_far (.sys_clk_in(sys_clk_in), .osc_on_in(osc_on), .pll_ok_in(pll_ok),
      .clk_ok_in(clk_ok), .src_out(srcs), .osc_out(osc));
   initial begin
      sys_clk_in = 1'b0;
      forever #20 sys_clk_in = ~sys_clk_in;
   end
   always @(posedge sys_clk_in) cyc <= cyc + 1;
   function automatic int rel_cycles(input int kind, input logic regen);
      int st;
      st = regen ? `RDS_CYC(`RDS_T_STARTUP_REG_NS) : PW;
      return (kind == 0 ? `RDS_CYC(`RDS_T_POR_NS) : 0) + (kind < 2 ? st : 0) + `RDS_CYC(`RDS_T_RST_NS);
   endfunction
   function automatic int clk_cycles(input logic pll);
      return `RDS_OST_PERIODS * 2 * TK + (pll ? `RDS_CYC(`RDS_T_LOCK_NS) : 0);
   endfunction
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("unexpected %s expected %0h seen %0h", nm, exp, got);
      end
   endtask
   task automatic chk_rng(input string nm, input int lo, input int hi, input int got);
      samples_checked++;
      if (got < lo || got > hi) begin
         failures++;
         $display("unexpected %s expected %0d to %0d seen %0d", nm, lo, hi, got);
      end
   endtask
   task automatic wait_val(input int w, input logic v, input int bound);
      int n;
      n = 0;
      while (outs[w] !== v) begin
         if (n == bound) begin
            failures++;
            $display("unexpected wait on output %0d expected %b seen %b", w, v, outs[w]);
            summarize();
         end
         @(posedge sys_clk_in);
         n++;
      end
   endtask
   // one single word transfer; hready is sampled at each edge before anything moves on
   task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      haddr <= {20'h0, a};
      htrans <= 2'b10;
      hwrite <= wr;
      hsel <= 1'b1;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (hready !== 1'b1 && n < 50);
      if (hready !== 1'b1) begin
         failures++;
         $display("unexpected bus address phase expected ready seen %b", hready);
         summarize();
      end
      htrans <= 2'b00;
      hwdata <= wd;
      do begin
         @(posedge sys_clk_in);
         n++;
      end while (hready !== 1'b1 && n < 100);
      if (hready !== 1'b1) begin
         failures++;
         $display("unexpected bus data phase expected ready seen %b", hready);
         summarize();
      end
      rd = hrdata;
      chk_rng("bus wait", 2, 99, n);
      chk("bus response", 0, hresp);
   endtask
   task automatic power_on(input rds_clk_src_type cs, input int hold);
      src <= cs;
      rst_n_in <= 1'b0;
      repeat (hold) @(posedge sys_clk_in);
      rst_n_in <= 1'b1;
      t0 = cyc;
      wait_val(0, 0, 70000);
   endtask
   task automatic pin_reset(input int idx, input int exp);
      repeat ($urandom % 8) @(posedge sys_clk_in);
      t0 = cyc;
      if (idx < 0) ahb(1, `RDS_OFF_CTRL, 32'hb);
      else u_far.fire(idx);
      wait_val(0, 1, 20);
      wait_val(0, 0, 70000);
      chk_rng("reset release", exp - 2, exp + 10, cyc - t0);
      $display("reset source %0d done", idx);
   endtask
   initial begin
      failures = 0;
      samples_checked = 0;
      cyc = 0;
      rst_n_in = 1'b0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsel = 1'b0;
      haddr = '0;
      hwdata = '0;
      src = rds_src_ext;
      osc_on = 1'b0;
      pll_ok = 1'b0;
      clk_ok = 1'b1;
      void'($urandom(32'hf1c5));
      power_on(rds_src_ext, 16);
      chk_rng("power-on release", rel_cycles(0, 1) - 2, rel_cycles(0, 1) + 6, cyc - t0);
      wait_val(2, 1, 4);
      @(posedge sys_clk_in);
      chk("run enable", 1, run);
      ahb(0, `RDS_OFF_CTRL, 0);
      chk("control reset", 32'h3, rd);
      ahb(0, `RDS_OFF_MASK, 0);
      chk("mask reset", 0, rd);
      ahb(1, 12'h010, 32'hffff_ffff);
      ahb(0, 12'h010, 0);
      chk("unmapped", 0, rd);
      ahb(0, `RDS_OFF_STATE, 0);
      s = rd;
      ahb(1, `RDS_OFF_STATE, ~s);
      ahb(0, `RDS_OFF_STATE, 0);
      chk("state read-only", s, rd);
      ahb(0, `RDS_OFF_STAT, 0);
      s = rd;
      chk("release event", 1, s[0]);
      m = $urandom % 16;
      ahb(1, `RDS_OFF_MASK, m);
      repeat (3) @(posedge sys_clk_in);
      chk("irq random mask", |(m & s & 32'hf), irq);
      ahb(1, `RDS_OFF_MASK, 32'h1);
      repeat (3) @(posedge sys_clk_in);
      chk("irq unmasked", 1, irq);
      ahb(1, `RDS_OFF_STAT, 32'h1);
      repeat (3) @(posedge sys_clk_in);
      chk("irq cleared", 0, irq);
      $display("power-on and registers done");
      for (i = 1; i <= 5; i++) pin_reset(i, rel_cycles(2, 1));
      pin_reset(-1, rel_cycles(2, 1));
      pin_reset(6, rel_cycles(1, 1));
      ahb(1, `RDS_OFF_CTRL, 32'h2);
      pin_reset(6, rel_cycles(1, 0));
      ahb(1, `RDS_OFF_CTRL, 32'h3);
      u_far.fire(0);
      k = 0;
      repeat (700) begin
         @(posedge sys_clk_in);
         if (rel !== 1'b0) k++;
      end
      chk("wake reset cycles", 0, k);
      $display("wake done");
      clk_ok <= 1'b0;
      osc_on <= 1'b1;
      power_on(rds_src_xtal, 2);
      chk("clock at reset release", 0, clk_rel);
      chk("run before clock", 0, run);
      k = cyc;
      wait_val(3, 1, MW + 10);
      chk_rng("monitor delay", MW - 1, MW + 4, cyc - k);
      repeat (2) @(posedge sys_clk_in);
      chk("fast rc", 1, internal_fast_rc_osc);
      clk_ok <= 1'b1;
      // the fast rc clock stands in until software switches back; the crystal release is still timed from the reset pin release at t0
      ahb(1, `RDS_OFF_CTRL, 32'h7);
      wait_val(4, 0, 6);
      chk("clock held after switch back", 0, clk_rel);
      wait_val(1, 1, 8000);
      chk_rng("crystal release", clk_cycles(0) - 2 * TK, clk_cycles(0) + 2 * TK + 10, cyc - t0);
      @(posedge sys_clk_in);
      chk("run after clock", 1, run);
      $display("crystal done");
      pll_ok <= 1'b1;
      power_on(rds_src_xtalpll, 2);
      wait_val(1, 1, 9000);
      chk_rng("pll release", clk_cycles(1) - 2 * TK, clk_cycles(1) + 2 * TK + 12, cyc - t0);
      pll_ok <= 1'b0;
      power_on(rds_src_extpll, 2);
      repeat (700) @(posedge sys_clk_in);
      chk("pll unlocked", 0, clk_rel);
      pll_ok <= 1'b1;
      wait_val(1, 1, 8);
      $display("pll done");
      summarize();
   end
endmodule

// ===== verilog/rds_defs.svh
`ifndef RDS_DEFS_SVH
`define RDS_DEFS_SVH
// nominal times in ns, cycle counts derived at 40 ns per clock
`define RDS_CLK_PERIOD_NS 40
`define RDS_T_POR_NS 10000
`define RDS_T_STARTUP_REG_NS 20000
`define RDS_T_POWER_UP_TIMER_NS 64000000
`define RDS_T_RST_NS 20000
`define RDS_T_LOCK_NS 20000
`define RDS_T_MON_NS 500000
`define RDS_CYC(ns) (((ns) + `RDS_CLK_PERIOD_NS - 1) / `RDS_CLK_PERIOD_NS)
`define RDS_OST_PERIODS 1024
// register byte offsets
`define RDS_OFF_CTRL 12'h000
`define RDS_OFF_STAT 12'h004
`define RDS_OFF_MASK 12'h008
`define RDS_OFF_STATE 12'h00c
// status bit positions
`define RDS_ST_RELEASE 0
`define RDS_ST_CLKOK 1
`define RDS_ST_FAIL 2
`define RDS_ST_MONON 3
`define RDS_NUM_ST 4
// control bit positions
`define RDS_CT_REGEN 0
`define RDS_CT_MONEN 1
`define RDS_CT_SRCBACK 2
`define RDS_CT_SWRST 3
`define RDS_CTRL_RESET 4'h3
`endif

// ===== verilog/rds_pkg.sv
package rds_pkg;
   typedef enum logic [2:0] {rds_src_ext, rds_src_extpll, rds_src_xtal, rds_src_xtalpll,
      rds_src_frc, rds_src_frcpll} rds_clk_src_type;
   typedef struct packed {
      logic por;
      logic bor;
      logic ext_clear;
      logic watchdog;
      logic illegal_op;
      logic uninit_w;
      logic trap_conflict;
      logic wake;
   } rds_src_type;
   typedef struct packed {
      logic osc_tick;
      logic pll_locked;
      logic clk_valid;
   } rds_osc_type;
endpackage

// ===== verilog/rds_reset_sequencer.sv
// Contract
// - A power-on reset holds system reset for the power-on delay plus start-up delay plus state reset time; brown-out skips the power-on delay.
// - The start-up delay is 20 us with the regulator enabled and the 64 ms power-up timer with it disabled.
// - Waking from a powered-down state applies the start-up delay only when the regulator is enabled.
// - Pin, watchdog, software, illegal-op, uninitialized-register and trap-conflict resets delay release by the state reset time only.
// - Crystal sources count 1024 oscillator periods on a 10-bit counter before the clock is released.
// - A PLL in the path adds the lock time before clock release, after the oscillator count for crystal plus PLL.
// - Oscillator and PLL timing run independently of the reset delays, so reset may release before the clock.
// - Execution does not start until a valid clock has been released, whatever the system reset.
// - The clock-failure monitor starts supervising when the system reset is released.
// - With no valid clock when monitoring starts, the device switches to the fast RC oscillator and raises a trap; software may switch back.
// - For crystal or PLL sources monitoring waits an extra start delay after the power-on and power-up timer delays.
`timescale 1ns/1ps
`include "rds_defs.svh"
module rds_reset_sequencer #(
   parameter int unsigned POWER_UP_TIMER_CYCLES = `RDS_CYC(`RDS_T_POWER_UP_TIMER_NS),
   parameter int unsigned MON_CYCLES = `RDS_CYC(`RDS_T_MON_NS)
) (
   input wire logic sys_clk_in,
   input wire logic rst_n_in,
   input wire rds_pkg::rds_src_type src_in,
   input wire rds_pkg::rds_osc_type osc_in,
   input wire rds_pkg::rds_clk_src_type clk_src_in,
   input wire logic [31:0] haddr_in,
   input wire logic [1:0] htrans_in,
   input wire logic hwrite_in,
   input wire logic [2:0] hsize_in,
   input wire logic hsel_in,
   input wire logic hready_in,
   input wire logic [31:0] hwdata_in,
   output logic [31:0] hrdata_out,
   output logic hreadyout_out,
   output logic hresp_out,
   output logic internal_system_reset_out,
   output logic clock_release_out,
   output logic run_enable_out,
   output logic use_fast_rc_out,
   output logic fail_trap_out,
   output logic monitor_active_out,
   output logic irq_out
);
   import rds_pkg::*;

   localparam int unsigned POR_C = `RDS_CYC(`RDS_T_POR_NS);
   localparam int unsigned SU_C = `RDS_CYC(`RDS_T_STARTUP_REG_NS);
   localparam int unsigned RST_C = `RDS_CYC(`RDS_T_RST_NS);
   localparam int unsigned LOCK_C = `RDS_CYC(`RDS_T_LOCK_NS);
   localparam logic [9:0] OST_LAST = 10'(`RDS_OST_PERIODS - 1);

   typedef enum logic [2:0] {rs_idle, rs_por, rs_startup, rs_state, rs_run} rds_rst_state_type;
   typedef enum logic [2:0] {cs_wait, cs_ost, cs_lock, cs_done} rds_clk_state_type;

   function automatic logic [31:0] rds_c32(input int unsigned v);
      rds_c32 = v[31:0];
   endfunction

   function automatic logic is_pll(input rds_clk_src_type s);
      is_pll = (s == rds_src_extpll) || (s == rds_src_xtalpll) || (s == rds_src_frcpll);
   endfunction

   function automatic logic is_xtal(input rds_clk_src_type s);
      is_xtal = (s == rds_src_xtal) || (s == rds_src_xtalpll);
   endfunction

   // two-flop synchronisers for every pin-side input
   logic [7:0] src_s1_reg, src_s2_reg, src_d_reg;
   logic [2:0] osc_s1_reg, osc_s2_reg, osc_d_reg;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         src_s1_reg <= 8'h00;
         src_s2_reg <= 8'h00;
         src_d_reg <= 8'h00;
         osc_s1_reg <= 3'h0;
         osc_s2_reg <= 3'h0;
         osc_d_reg <= 3'h0;
      end else begin
         src_s1_reg <= src_in;
         src_s2_reg <= src_s1_reg;
         src_d_reg <= src_s2_reg;
         osc_s1_reg <= osc_in;
         osc_s2_reg <= osc_s1_reg;
         osc_d_reg <= osc_s2_reg;
      end
   end
   rds_src_type src_rise;
   rds_osc_type osc_now;
   logic osc_tick_edge;
   assign src_rise = src_s2_reg & ~src_d_reg;
   assign osc_now = osc_s2_reg;
   assign osc_tick_edge = osc_s2_reg[2] & ~osc_d_reg[2];

   logic [3:0] ctrl_reg;
   logic [`RDS_NUM_ST-1:0] stat_reg, mask_reg;
   logic regen;
   assign regen = ctrl_reg[`RDS_CT_REGEN];

   // reset delay chain
   rds_rst_state_type rs_reg;
   logic [31:0] rs_cnt_reg;
   logic por_seen_reg;
   logic wake_path_reg;
   logic sw_req;
   logic any_short;
   assign any_short = src_rise.ext_clear | src_rise.watchdog | src_rise.illegal_op |
      src_rise.uninit_w | src_rise.trap_conflict | sw_req;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         rs_reg <= rs_idle;
         rs_cnt_reg <= 32'h0;
         por_seen_reg <= 1'b0;
      end else begin
         por_seen_reg <= 1'b1;
         if (!por_seen_reg || src_rise.por) begin
            rs_reg <= rs_por;
            rs_cnt_reg <= rds_c32(POR_C);
         end else if (src_rise.bor) begin
            rs_reg <= rs_startup;
            rs_cnt_reg <= regen ? rds_c32(SU_C) : rds_c32(POWER_UP_TIMER_CYCLES);
         end else if (any_short) begin
            rs_reg <= rs_state;
            rs_cnt_reg <= rds_c32(RST_C);
         end else if (src_rise.wake && regen && rs_reg == rs_run) begin
            rs_reg <= rs_startup;
            rs_cnt_reg <= rds_c32(SU_C);
         end else begin
            case (rs_reg)
               rs_idle: rs_reg <= rs_idle;
               rs_por, rs_startup, rs_state: begin
                  if (rs_cnt_reg > 32'h1) begin
                     rs_cnt_reg <= rs_cnt_reg - 32'h1;
                  end else if (rs_reg == rs_por) begin
                     rs_reg <= rs_startup;
                     rs_cnt_reg <= regen ? rds_c32(SU_C) : rds_c32(POWER_UP_TIMER_CYCLES);
                  end else if (rs_reg == rs_startup && !wake_path_reg) begin
                     rs_reg <= rs_state;
                     rs_cnt_reg <= rds_c32(RST_C);
                  end else begin
                     rs_reg <= rs_run;
                  end
               end
               rs_run: rs_reg <= rs_run;
               default: rs_reg <= rs_idle;
            endcase
         end
      end
   end
   // wake re-applies only the start-up delay, so a wake countdown ends straight in run;
   // a reset event that cuts in drops the wake path so its own full delay chain runs
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         wake_path_reg <= 1'b0;
      end else if (!por_seen_reg || src_rise.por || src_rise.bor || any_short) begin
         wake_path_reg <= 1'b0;
      end else if (src_rise.wake && regen && rs_reg == rs_run) begin
         wake_path_reg <= 1'b1;
      end else if (rs_reg != rs_startup) begin
         wake_path_reg <= 1'b0;
      end
   end
   logic sys_rst_reg;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         sys_rst_reg <= 1'b1;
      end else begin
         sys_rst_reg <= (rs_reg != rs_run) && !(wake_path_reg && rs_reg == rs_startup);
      end
   end

   // clock release chain runs on its own, restarted only by power events
   rds_clk_state_type cs_reg;
   logic [9:0] ost_cnt_reg;
   logic [31:0] lock_cnt_reg;
   logic power_evt;
   assign power_evt = !por_seen_reg || src_rise.por || src_rise.bor;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         cs_reg <= cs_wait;
         ost_cnt_reg <= 10'h000;
         lock_cnt_reg <= 32'h0;
      end else if (power_evt) begin
         cs_reg <= cs_wait;
         ost_cnt_reg <= 10'h000;
         lock_cnt_reg <= rds_c32(LOCK_C);
      end else begin
         case (cs_reg)
            cs_wait: cs_reg <= is_xtal(clk_src_in) ? cs_ost : (is_pll(clk_src_in) ? cs_lock : cs_done);
            cs_ost: begin
               if (osc_tick_edge) begin
                  ost_cnt_reg <= ost_cnt_reg + 10'h001;
                  if (ost_cnt_reg == OST_LAST) begin
                     cs_reg <= is_pll(clk_src_in) ? cs_lock : cs_done;
                  end
               end
            end
            cs_lock: begin
               if (lock_cnt_reg > 32'h1) begin
                  lock_cnt_reg <= lock_cnt_reg - 32'h1;
               end else if (osc_now.pll_locked) begin
                  cs_reg <= cs_done;
               end
            end
            cs_done: cs_reg <= cs_done;
            default: cs_reg <= cs_wait;
         endcase
      end
   end

   // monitor start: extra delay only for crystal or pll sources
   logic [31:0] mon_cnt_reg;
   logic mon_on_reg, mon_armed_reg, fast_rc_reg, trap_reg;
   logic mon_need;
   assign mon_need = is_xtal(clk_src_in) || is_pll(clk_src_in);
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         mon_cnt_reg <= 32'h0;
         mon_on_reg <= 1'b0;
         mon_armed_reg <= 1'b0;
      end else if (sys_rst_reg || !ctrl_reg[`RDS_CT_MONEN]) begin
         mon_on_reg <= 1'b0;
         mon_armed_reg <= 1'b0;
         mon_cnt_reg <= mon_need ? rds_c32(MON_CYCLES) : 32'h0;
      end else if (mon_cnt_reg != 32'h0) begin
         mon_cnt_reg <= mon_cnt_reg - 32'h1;
      end else begin
         mon_on_reg <= 1'b1;
         mon_armed_reg <= mon_on_reg;
      end
   end
   logic fail_now;
   assign fail_now = mon_on_reg && !mon_armed_reg && !osc_now.clk_valid && !fast_rc_reg;
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         fast_rc_reg <= 1'b0;
         trap_reg <= 1'b0;
      end else begin
         trap_reg <= fail_now;
         if (fail_now) begin
            fast_rc_reg <= 1'b1;
         end else if (ctrl_reg[`RDS_CT_SRCBACK]) begin
            fast_rc_reg <= 1'b0;
         end
      end
   end
   logic clk_ok;
   assign clk_ok = (cs_reg == cs_done) || fast_rc_reg;

   // ahb-lite slave, zero wait states
   logic ph_wr_reg, ph_rd_reg;
   logic [11:0] ph_addr_reg;
   logic take;
   assign take = hsel_in && hready_in && htrans_in[1];
   assign sw_req = ph_wr_reg && ph_addr_reg == `RDS_OFF_CTRL && hwdata_in[`RDS_CT_SWRST];
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ph_wr_reg <= 1'b0;
         ph_rd_reg <= 1'b0;
         ph_addr_reg <= 12'h000;
      end else begin
         ph_wr_reg <= take && hwrite_in;
         ph_rd_reg <= take && !hwrite_in;
         if (take) begin
            ph_addr_reg <= haddr_in[11:0];
         end
      end
   end
   logic [`RDS_NUM_ST-1:0] evt;
   assign evt = {mon_on_reg & ~mon_armed_reg, fail_now,
      clk_ok & (cs_reg != cs_done || !sys_rst_reg) & ~stat_reg[`RDS_ST_CLKOK] & run_enable_out,
      ~sys_rst_reg & internal_system_reset_out};
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         ctrl_reg <= `RDS_CTRL_RESET;
         mask_reg <= 4'h0;
         stat_reg <= 4'h0;
      end else begin
         if (ph_wr_reg && ph_addr_reg == `RDS_OFF_CTRL) begin
            ctrl_reg <= {1'b0, hwdata_in[`RDS_CT_SRCBACK:0]};
         end else begin
            ctrl_reg[`RDS_CT_SRCBACK] <= 1'b0;
         end
         if (ph_wr_reg && ph_addr_reg == `RDS_OFF_MASK) begin
            mask_reg <= hwdata_in[`RDS_NUM_ST-1:0];
         end
         // a set in the same cycle beats the write-one clear
         if (ph_wr_reg && ph_addr_reg == `RDS_OFF_STAT) begin
            stat_reg <= (stat_reg & ~hwdata_in[`RDS_NUM_ST-1:0]) | evt;
         end else begin
            stat_reg <= stat_reg | evt;
         end
      end
   end
   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         hrdata_out <= 32'h0;
      end else if (take && !hwrite_in) begin
         case (haddr_in[11:0])
            `RDS_OFF_CTRL: hrdata_out <= {28'h0, ctrl_reg};
            `RDS_OFF_STAT: hrdata_out <= {28'h0, stat_reg};
            `RDS_OFF_MASK: hrdata_out <= {28'h0, mask_reg};
            `RDS_OFF_STATE: hrdata_out <= {24'h0, 1'b0, rs_reg, 1'b0, cs_reg};
            default: hrdata_out <= 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
         internal_system_reset_out <= 1'b1;
         clock_release_out <= 1'b0;
         run_enable_out <= 1'b0;
         use_fast_rc_out <= 1'b0;
         fail_trap_out <= 1'b0;
         monitor_active_out <= 1'b0;
         irq_out <= 1'b0;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end else begin
         internal_system_reset_out <= sys_rst_reg;
         clock_release_out <= clk_ok;
         run_enable_out <= !sys_rst_reg && clk_ok;
         use_fast_rc_out <= fast_rc_reg;
         fail_trap_out <= trap_reg;
         monitor_active_out <= mon_on_reg;
         irq_out <= |(stat_reg & mask_reg);
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
      end
   end

   sequence s_state_done;
      rs_reg == rs_state && rs_cnt_reg == 32'h1;
   endsequence
   a_short_reset_len: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(rs_reg == rs_state) |-> rs_cnt_reg == rds_c32(RST_C))
      else $error("state reset count wrong");
   a_state_to_run: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      (s_state_done and (!power_evt && !any_short && !src_rise.wake)) |=> rs_reg == rs_run)
      else $error("state reset did not end in run");
   a_startup_pick: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      rs_reg == rs_por && rs_cnt_reg == 32'h1 && !power_evt && !any_short && !src_rise.wake |=>
      rs_reg == rs_startup && rs_cnt_reg == ($past(regen) ? rds_c32(SU_C) : rds_c32(POWER_UP_TIMER_CYCLES)))
      else $error("start-up delay wrong");
   a_bor_no_por: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      por_seen_reg && src_rise.bor && !src_rise.por |=> rs_reg == rs_startup)
      else $error("brown-out ran power-on delay");
   a_run_needs_clk: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      run_enable_out |-> clock_release_out && !internal_system_reset_out)
      else $error("run without clock");
   a_ost_count: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      cs_reg == cs_ost && osc_tick_edge && ost_cnt_reg != OST_LAST && !power_evt |=> cs_reg == cs_ost)
      else $error("oscillator count ended early");
   a_monitor_start: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $rose(mon_on_reg) |-> !$past(sys_rst_reg) && $past(mon_cnt_reg) == 32'h0)
      else $error("monitor started early");
   a_mon_delay_len: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      $fell(sys_rst_reg) && mon_need && ctrl_reg[`RDS_CT_MONEN] |-> !mon_on_reg [*8])
      else $error("monitor start delay skipped");
   a_fail_switch: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
      fail_now |=> fast_rc_reg ##1 fail_trap_out) else $error("no switch on clock failure");
endmodule
